// file: src/ssd_safety_diag.sv
// Safety diagnostic controller: self-test supervision, fault state sequencing, rail enables and diag mux control.
// Assumes analog comparators, thermal and current-limit flags arrive asynchronously; MCU requests are on ref_clk.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Clock test emulates failure, sets loss status.
// - MCU may recheck clock monitor in diag/active.
// - Self-test covers comparators, clock, trim checksum.
// - Self-test failure: safe state, reset low, latch.
// - Wake after failure goes reset then diagnostic.
// - Diagnostic state exposes self-test status to MCU.
// - Any check startable in diagnostic or active.
// - Supply supervision suspended during self-test run.
// - Full self-test run lasts about two milliseconds.
// - 5V or sensor thermal shutdown clears that rail's enable until software sets it again.
// - I/O thermal shutdown: standby, all off, reset.
// - 5V thermal shutdown: reset state, others stay.
// - Current limit sets that rail's status bit.
// - Select register chooses the diagnostic source.
// - Config bit 7 globally enables the multiplexer.
// - Type 10 selects analog, codes 0-7.
// - Type 01 selects digital, group and channel.
// - Group 000 fixed channel assignment.
// - Further groups 001,010,011,111 as listed.
// - Real clock loss: standby, all off, latched.
module ssd_safety_diag
  import ssd_pkg::*;
#(
  parameter int ANALOG_SELFTEST_CTRL_CYCLES = ANALOG_SELFTEST_CTRL_CYCLES_DEF,
  parameter int RESET_EXT    = RESET_EXT_DEF
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         ignition_wake_in,
  input  wire logic         bus_wake_in,
  input  wire logic         clock_loss_monitor,
  input  wire logic         analog_supply_uv_flag,
  input  wire logic [12:0]  rail_cmp_in,
  input  wire logic [2:0]   ot_in,
  input  wire logic [2:0]   ilim_in,
  input  wire logic [15:0]  digital_source_mux_grp1_in,
  input  wire logic [15:0]  digital_source_mux_grp2_in,
  input  wire logic [15:0]  digital_source_mux_grp3_in,
  input  wire logic [15:0]  digital_source_mux_grp7_in,
  input  wire logic         trim_crc_ok,
  input  wire logic         analog_selftest_ctrl_start,
  input  wire logic [2:0]   analog_selftest_ctrl_sel,
  input  wire logic         clk_recheck,
  input  wire logic         status_read,
  input  wire logic         go_active,
  input  wire logic         en_5v_set,
  input  wire logic         en_sensor_set,
  input  wire logic [7:0]   diag_config_reg,
  input  wire logic [6:0]   diag_source_select,
  output logic              mcu_reset_out_n,
  output logic [4:0]        dev_state,
  output logic              analog_selftest_ctrl_running,
  output logic [3:0]        analog_selftest_ctrl_status,
  output logic              rail_voltage_supervisor_emul_en,
  output logic              clk_fail_emul,
  output logic              clock_loss_flag,
  output logic              supply_supervision_en,
  output logic              buck_prereg_rail_en,
  output logic              io_rail_cfg_en,
  output logic              rail_5v_fixed_en,
  output logic              sensor_rail_en,
  output logic [2:0]        ilim_status,
  output logic              clk_fail_latched,
  output logic              diag_output_pin,
  output logic              analog_mux_en,
  output logic [2:0]        analog_mux_ch
);

  localparam int CNT_W = $clog2(ANALOG_SELFTEST_CTRL_CYCLES + 1);
  localparam int EXT_W = $clog2(RESET_EXT + 1);
  localparam logic [CNT_W-1:0] RUN_LEN = CNT_W'(ANALOG_SELFTEST_CTRL_CYCLES);
  localparam logic [EXT_W-1:0] EXT_LEN = EXT_W'(RESET_EXT);
  localparam logic [TOG_W-1:0] TOG_MIN = TOG_W'(MIN_TOGGLES);
  localparam logic [TOG_W-1:0] TOG_MAX = '1;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [PIN_W-1:0] prev;
    ssd_state_t       state;
    logic [EXT_W-1:0] ext_cnt;
    logic             running;
    logic [CNT_W-1:0] run_cnt;
    logic [2:0]       mask;
    logic [TOG_W-1:0] vtog;
    logic [TOG_W-1:0] ctog;
    logic [3:0]       status;
    logic             loss_stat;
    logic             buck_en;
    logic             io_en;
    logic             en5;
    logic             ens;
    logic [2:0]       ilim;
    logic             clk_latch;
  } ssd_st_t;

  ssd_st_t r;
  ssd_st_t next_r;

  logic [PIN_W-1:0] pins;
  logic             wake;
  logic             wake_rise;
  logic             clk_mon;
  logic             real_loss;
  logic             ot_io;
  logic             ot_5v;
  logic             ot_sns;
  logic             req_ok;
  logic             run_end;
  logic [2:0]       fail_bits;
  logic             fail_now;

  assign pins = {digital_source_mux_grp7_in, digital_source_mux_grp3_in, digital_source_mux_grp2_in, digital_source_mux_grp1_in, rail_cmp_in,
                 ilim_in, ot_in, analog_supply_uv_flag, clock_loss_monitor, bus_wake_in, ignition_wake_in};

  always_comb begin
    wake      = r.sync2[P_IGN] | r.sync2[P_BUS];
    wake_rise = (r.sync2[P_IGN] & ~r.prev[P_IGN]) | (r.sync2[P_BUS] & ~r.prev[P_BUS]);
    clk_mon   = r.sync2[P_CLKMON];
    real_loss = clk_mon & ~(r.running & r.mask[CHK_CLK]);
    ot_io     = r.sync2[P_OT + RAIL_IO];
    ot_5v     = r.sync2[P_OT + RAIL_5V];
    ot_sns    = r.sync2[P_OT + RAIL_SNS];
    req_ok    = (r.state == ST_DIAG || r.state == ST_ACTIVE) && !r.running
                && ((analog_selftest_ctrl_start && analog_selftest_ctrl_sel != 3'h0) || clk_recheck);
    run_end   = r.running && (r.run_cnt == CNT_W'(1));
    fail_bits[CHK_RAIL_VOLTAGE_SUPERVISOR] = r.mask[CHK_RAIL_VOLTAGE_SUPERVISOR] && (r.vtog < TOG_MIN);
    fail_bits[CHK_CLK]  = r.mask[CHK_CLK] && (r.ctog < TOG_MIN);
    fail_bits[CHK_TRIM] = r.mask[CHK_TRIM] && !trim_crc_ok;
    fail_now  = run_end && (fail_bits != 3'h0);
  end

  always_comb begin
    next_r       = r;
    next_r.sync1 = pins;
    next_r.sync2 = r.sync1;
    next_r.prev  = r.sync2;

    // Read clears first; any flag set in the same cycle overrides it.
    if (status_read) begin
      next_r.status = 4'h0;
      next_r.ilim   = 3'h0;
    end
    next_r.ilim = next_r.ilim | r.sync2[P_ILIM +: 3];

    // Self-test sequencer.
    if (req_ok) begin
      next_r.running = 1'b1;
      next_r.run_cnt = RUN_LEN;
      next_r.mask    = clk_recheck ? CHK_CLK_ONLY : analog_selftest_ctrl_sel;
      next_r.vtog    = '0;
      next_r.ctog    = '0;
    end else if (r.running) begin
      next_r.run_cnt = r.run_cnt - CNT_W'(1);
      if (r.sync2[P_CMP +: CMP_W] != r.prev[P_CMP +: CMP_W] && r.vtog != TOG_MAX) begin
        next_r.vtog = r.vtog + TOG_W'(1);
      end
      if (clk_mon != r.prev[P_CLKMON] && r.ctog != TOG_MAX) begin
        next_r.ctog = r.ctog + TOG_W'(1);
      end
      if (run_end) begin
        next_r.running = 1'b0;
      end
    end
    if (fail_now) begin
      next_r.status[2:0] = next_r.status[2:0] | fail_bits;
    end
    next_r.loss_stat = (r.running && r.mask[CHK_CLK] && clk_mon) || r.clk_latch;

    // Software enables; a standing over-temperature blocks the set.
    if (en_5v_set && !ot_5v && r.state != ST_STANDBY) begin
      next_r.en5 = 1'b1;
    end
    if (en_sensor_set && !ot_sns && r.state != ST_STANDBY) begin
      next_r.ens = 1'b1;
    end
    if (ot_sns) begin
      next_r.ens = 1'b0;
    end

    // Device state sequencing, highest priority fault first.
    if (real_loss) begin
      next_r.state     = ST_STANDBY;
      next_r.clk_latch = 1'b1;
      next_r.running   = 1'b0;
      next_r.buck_en   = 1'b0;
      next_r.io_en     = 1'b0;
      next_r.en5       = 1'b0;
      next_r.ens       = 1'b0;
      next_r.ext_cnt   = '0;
    end else if (ot_io) begin
      next_r.state   = ST_STANDBY;
      next_r.running = 1'b0;
      next_r.buck_en = 1'b0;
      next_r.io_en   = 1'b0;
      next_r.en5     = 1'b0;
      next_r.ens     = 1'b0;
    end else if (fail_now) begin
      next_r.state = ST_SAFE;
    end else if (ot_5v && r.state != ST_STANDBY) begin
      next_r.state   = ST_RESET;
      next_r.en5     = 1'b0;
      next_r.ext_cnt = EXT_LEN;
    end else begin
      case (r.state)
        ST_STANDBY: begin
          if (wake && !r.clk_latch) begin
            next_r.state   = ST_RESET;
            next_r.ext_cnt = EXT_LEN;
            next_r.buck_en = 1'b1;
            next_r.io_en   = 1'b1;
            next_r.en5     = 1'b1;
          end
        end
        ST_RESET: begin
          if (r.ext_cnt == '0) begin
            next_r.state = ST_DIAG;
          end else begin
            next_r.ext_cnt = r.ext_cnt - EXT_W'(1);
          end
        end
        ST_DIAG: begin
          if (go_active && !r.running) begin
            next_r.state = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          next_r.state = ST_ACTIVE;
        end
        ST_SAFE: begin
          if (wake_rise) begin
            next_r.state              = ST_RESET;
            next_r.ext_cnt            = EXT_LEN;
            next_r.status[STA_REBOOT] = 1'b1;
          end
        end
        default: begin
          next_r.state = ST_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r       <= '0;
      r.state <= ST_STANDBY;
    end else begin
      r <= next_r;
    end
  end

  assign mcu_reset_out_n       = (r.state == ST_DIAG) || (r.state == ST_ACTIVE);
  assign dev_state             = r.state;
  assign analog_selftest_ctrl_running         = r.running;
  assign analog_selftest_ctrl_status          = r.status;
  assign rail_voltage_supervisor_emul_en          = r.running & r.mask[CHK_RAIL_VOLTAGE_SUPERVISOR];
  assign clk_fail_emul         = r.running & r.mask[CHK_CLK];
  assign clock_loss_flag       = r.loss_stat;
  assign supply_supervision_en = ~r.running;
  assign buck_prereg_rail_en   = r.buck_en;
  assign io_rail_cfg_en        = r.io_en;
  assign rail_5v_fixed_en      = r.en5;
  assign sensor_rail_en        = r.ens;
  assign ilim_status           = r.ilim;
  assign clk_fail_latched      = r.clk_latch;

  ssd_mux_if mif ();

  assign mif.mux_en   = diag_config_reg[MUX_EN_BIT];
  assign mif.mux_type = diag_config_reg[MUX_TYPE_LSB +: 2];
  assign mif.sel      = diag_source_select;
  assign mif.grp0     = {r.loss_stat, r.sync2[P_CMP +: CMP_W], r.sync2[P_AVDD], 1'b0};
  assign mif.grp1     = {r.sync2[P_G1 + 1 +: 15], 1'b0};
  assign mif.grp2     = {r.sync2[P_G2 + 1 +: 15], 1'b0};
  assign mif.grp3     = {r.sync2[P_G3 + 1 +: 15], 1'b0};
  assign mif.grp7     = {r.sync2[P_G7 + 1 +: 15], 1'b0};

  ssd_diag_mux u_mux (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .m       (mif.mux)
  );

  assign diag_output_pin = mif.dout;
  assign analog_mux_en   = mif.ana_en;
  assign analog_mux_ch   = mif.ana_ch;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_safe_reset_low: assert property (r.state == ST_SAFE |-> !mcu_reset_out_n)
    else $error("Reset to MCU released in safe state.");
  a_fail_to_safe: assert property (fail_now && !real_loss && !ot_io |=> r.state == ST_SAFE && (r.status[2:0] != 3'h0))
    else $error("Self-test failure did not reach safe state.");
  a_run_start_ok: assert property ($rose(r.running) |-> $past(r.state == ST_DIAG || r.state == ST_ACTIVE))
    else $error("Self-test started outside diagnostic or active state.");
  a_run_length: assert property ($rose(r.running) |-> r.run_cnt == RUN_LEN)
    else $error("Self-test run length wrong.");
  a_superv_off: assert property (r.running |-> !supply_supervision_en)
    else $error("Supply supervision active during self-test.");
  a_clk_status: assert property (r.running && r.mask[CHK_CLK] && clk_mon |=> clock_loss_flag)
    else $error("Loss-of-clock status not set during clock test.");
  a_io_thermal: assert property (ot_io && !real_loss |=> r.state == ST_STANDBY && !io_rail_cfg_en && !rail_5v_fixed_en)
    else $error("I/O thermal shutdown did not reach standby.");
  a_5v_thermal: assert property (ot_5v && !real_loss && !ot_io && !fail_now && r.state != ST_STANDBY |=>
    r.state == ST_RESET && !rail_5v_fixed_en && io_rail_cfg_en == $past(r.io_en))
    else $error("5V thermal shutdown handled wrongly.");
  a_ilim_set: assert property (r.sync2[P_ILIM + RAIL_5V] |=> ilim_status[RAIL_5V])
    else $error("Current limit status bit not set.");
  a_loss_latch: assert property (clk_fail_latched |=> clk_fail_latched && r.state == ST_STANDBY)
    else $error("Clock failure latch dropped.");
  a_flags_keep: assert property (r.status[2:0] != 3'h0 && !status_read |=> r.status[2:0] != 3'h0)
    else $error("Self-test flags cleared without read.");
  a_safe_wake: assert property (r.state == ST_SAFE && wake_rise && !real_loss && !ot_io && !ot_5v |=> r.state == ST_RESET)
    else $error("Wake from safe state did not enter reset.");

  c_run_pass: cover property ($fell(r.running) && r.state == ST_DIAG);
  c_run_fail: cover property (fail_now ##1 r.state == ST_SAFE);
  c_reboot: cover property (r.state == ST_SAFE ##[1:1000] r.state == ST_DIAG);

endmodule // ssd_safety_diag
`default_nettype wire

// file: src/ssd_pkg.sv
// Shared constants and types for the safety self-test and diagnostic multiplexer logic.
// Assumes a single 125 MHz clock domain and an asynchronous active-low power-on reset.
package ssd_pkg;

  // Clock and timing.
  localparam int CLK_MHZ           = 125;
  localparam int ANALOG_SELFTEST_CTRL_TIME_US     = 2000;
  localparam int ANALOG_SELFTEST_CTRL_CYCLES_DEF  = ANALOG_SELFTEST_CTRL_TIME_US * CLK_MHZ;
  localparam int RESET_EXT_DEF     = 64;
  localparam int MIN_TOGGLES       = 4;
  localparam int TOG_W             = 8;

  // Device states, one-hot.
  typedef enum logic [4:0] {
    ST_STANDBY = 5'h01,
    ST_RESET   = 5'h02,
    ST_DIAG    = 5'h04,
    ST_ACTIVE  = 5'h08,
    ST_SAFE    = 5'h10
  } ssd_state_t;

  // Self-test check selection and status bit positions.
  localparam int CHK_RAIL_VOLTAGE_SUPERVISOR   = 0;
  localparam int CHK_CLK    = 1;
  localparam int CHK_TRIM   = 2;
  localparam int STA_REBOOT = 3;
  localparam logic [2:0] CHK_CLK_ONLY = 3'h2;

  // Rail index inside the thermal and current-limit vectors.
  localparam int RAIL_IO  = 0;
  localparam int RAIL_5V  = 1;
  localparam int RAIL_SNS = 2;

  // Bit positions in the synchronised pin vector.
  localparam int P_IGN    = 0;
  localparam int P_BUS    = 1;
  localparam int P_CLKMON = 2;
  localparam int P_AVDD   = 3;
  localparam int P_OT     = 4;
  localparam int P_ILIM   = 7;
  localparam int P_CMP    = 10;
  localparam int CMP_W    = 13;
  localparam int P_G1     = 23;
  localparam int P_G2     = 39;
  localparam int P_G3     = 55;
  localparam int P_G7     = 71;
  localparam int PIN_W    = 87;

  // Diagnostic configuration register layout and multiplexer codes.
  localparam int         MUX_EN_BIT   = 7;
  localparam int         MUX_TYPE_LSB = 0;
  localparam logic [1:0] MUX_TYPE_ANA = 2'h2;
  localparam logic [1:0] MUX_TYPE_DIG = 2'h1;
  localparam logic [3:0] ANA_MAX_CODE = 4'h7;
  localparam logic [2:0] GRP_0        = 3'h0;
  localparam logic [2:0] GRP_1        = 3'h1;
  localparam logic [2:0] GRP_2        = 3'h2;
  localparam logic [2:0] GRP_3        = 3'h3;
  localparam logic [2:0] GRP_7        = 3'h7;

endpackage

// file: src/ssd_mux_if.sv
// Interface between the safety controller and the diagnostic output multiplexer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ssd_mux_if;
  logic        mux_en;
  logic [1:0]  mux_type;
  logic [6:0]  sel;
  logic [15:0] grp0;
  logic [15:0] grp1;
  logic [15:0] grp2;
  logic [15:0] grp3;
  logic [15:0] grp7;
  logic        dout;
  logic        ana_en;
  logic [2:0]  ana_ch;
  modport ctrl (output mux_en, mux_type, sel, grp0, grp1, grp2, grp3, grp7, input dout, ana_en, ana_ch);
  modport mux  (input mux_en, mux_type, sel, grp0, grp1, grp2, grp3, grp7, output dout, ana_en, ana_ch);
endinterface
`default_nettype wire

// file: src/ssd_diag_mux.sv
// Diagnostic output multiplexer: routes an analog source selection or one digital channel to the pin.
// Assumes group vectors are already synchronised to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ssd_diag_mux
  import ssd_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  ssd_mux_if.mux    m
);

  typedef struct packed {
    logic       dout;
    logic       ana_en;
    logic [2:0] ana_ch;
  } ssd_mux_st_t;

  ssd_mux_st_t r;
  ssd_mux_st_t next_r;

  always_comb begin
    next_r = '0;
    if (m.mux_en && m.mux_type == MUX_TYPE_ANA) begin
      next_r.ana_en = (m.sel[3:0] <= ANA_MAX_CODE);
      next_r.ana_ch = m.sel[2:0];
    end else if (m.mux_en && m.mux_type == MUX_TYPE_DIG) begin
      case (m.sel[6:4])
        GRP_0:   next_r.dout = m.grp0[m.sel[3:0]];
        GRP_1:   next_r.dout = m.grp1[m.sel[3:0]];
        GRP_2:   next_r.dout = m.grp2[m.sel[3:0]];
        GRP_3:   next_r.dout = m.grp3[m.sel[3:0]];
        GRP_7:   next_r.dout = m.grp7[m.sel[3:0]];
        default: next_r.dout = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign m.dout   = r.dout;
  assign m.ana_en = r.ana_en;
  assign m.ana_ch = r.ana_ch;

  a_mux_off_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!m.mux_en || (m.mux_type != MUX_TYPE_ANA && m.mux_type != MUX_TYPE_DIG)) |=> (!m.dout && !m.ana_en))
    else $error("Diagnostic output not low while multiplexer is off.");
  a_ana_route: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (m.mux_en && m.mux_type == MUX_TYPE_ANA && m.sel[3:0] <= ANA_MAX_CODE) |=> (m.ana_en && m.ana_ch == $past(m.sel[2:0])))
    else $error("Analog source not routed as selected.");
  a_dig_group0: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (m.mux_en && m.mux_type == MUX_TYPE_DIG && m.sel[6:4] == GRP_0) |=> (m.dout == $past(m.grp0[m.sel[3:0]])))
    else $error("Digital group zero channel not routed.");
  c_dig_mode: cover property (@(posedge ref_clk) disable iff (!rst_b) m.mux_en && m.mux_type == MUX_TYPE_DIG ##1 m.dout);

endmodule // ssd_diag_mux
`default_nettype wire

// file: testbench/ssd_mcu_model.sv
// Model of the safety microcontroller: request pulses and diagnostic multiplexer configuration.
// Assumes one shared clock and requests launched at its rising edges.
`timescale 1ns/1ps
`default_nettype none
module ssd_mcu_model (
  input  wire logic  ref_clk,
  output logic       analog_selftest_ctrl_start,
  output logic [2:0] analog_selftest_ctrl_sel,
  output logic       clk_recheck,
  output logic       status_read,
  output logic       go_active,
  output logic       en_5v_set,
  output logic       en_sensor_set,
  output logic [7:0] diag_config_reg,
  output logic [6:0] diag_source_select
);
  initial begin
    {analog_selftest_ctrl_start, clk_recheck, status_read, go_active, en_5v_set, en_sensor_set} = 6'h00;
    analog_selftest_ctrl_sel = 3'h0;
    diag_config_reg = 8'h00;
    diag_source_select = 7'h00;
  end
  // Sends one pulse: start, recheck, read, active, 5v set, sensor set.
  task automatic req(input logic [5:0] k, input logic [2:0] s);
    @(posedge ref_clk);
    {analog_selftest_ctrl_start, clk_recheck, status_read, go_active, en_5v_set, en_sensor_set} <= k;
    analog_selftest_ctrl_sel <= s;
    @(posedge ref_clk);
    {analog_selftest_ctrl_start, clk_recheck, status_read, go_active, en_5v_set, en_sensor_set} <= 6'h00;
  endtask
  // Type and selection change together so the pin kind never mixes.
  task automatic cfg(input logic [7:0] c, input logic [6:0] s);
    @(posedge ref_clk);
    diag_config_reg <= c;
    diag_source_select <= s;
  endtask
endmodule // ssd_mcu_model
`default_nettype wire

// file: testbench/safety_selftest_diag_mux_tb_top.sv
// Self-checking bench for the safety self-test and diagnostic multiplexer controller.
// Assumes the microcontroller model drives every request and configuration input.
`timescale 1ns/1ps
`default_nettype none
module safety_selftest_diag_mux_tb_top
  import ssd_pkg::*;
;
  localparam logic [5:0] K_RUN = 6'h20, K_CLK = 6'h10, K_RD = 6'h08, K_ACT = 6'h04, K_5V = 6'h02, K_SNS = 6'h01;
  logic        ref_clk, rst_b, ignition_wake_in, bus_wake_in, clock_loss_monitor, analog_supply_uv_flag, trim_crc_ok;
  logic        analog_selftest_ctrl_start, clk_recheck, status_read, go_active, en_5v_set, en_sensor_set, seen, sup;
  logic        mcu_reset_out_n, analog_selftest_ctrl_running, rail_voltage_supervisor_emul_en, clk_fail_emul, clock_loss_flag, supply_supervision_en;
  logic        buck_prereg_rail_en, io_rail_cfg_en, rail_5v_fixed_en, sensor_rail_en, clk_fail_latched;
  logic        diag_output_pin, analog_mux_en;
  logic [12:0] rail_cmp_in;
  logic [2:0]  ot_in, ilim_in, analog_selftest_ctrl_sel, ilim_status, analog_mux_ch;
  logic [15:0] digital_source_mux_grp1_in, digital_source_mux_grp2_in, digital_source_mux_grp3_in, digital_source_mux_grp7_in;
  logic [7:0]  diag_config_reg;
  logic [6:0]  diag_source_select;
  logic [4:0]  dev_state;
  logic [3:0]  analog_selftest_ctrl_status;
  int          errors, total_checks, n, i;

  ssd_safety_diag #(.ANALOG_SELFTEST_CTRL_CYCLES(64), .RESET_EXT(4)) uut (
    .ref_clk, .rst_b, .ignition_wake_in, .bus_wake_in, .clock_loss_monitor, .analog_supply_uv_flag, .rail_cmp_in,
    .ot_in, .ilim_in, .digital_source_mux_grp1_in, .digital_source_mux_grp2_in, .digital_source_mux_grp3_in, .digital_source_mux_grp7_in, .trim_crc_ok, .analog_selftest_ctrl_start,
    .analog_selftest_ctrl_sel, .clk_recheck, .status_read, .go_active, .en_5v_set, .en_sensor_set, .diag_config_reg,
    .diag_source_select, .mcu_reset_out_n, .dev_state, .analog_selftest_ctrl_running, .analog_selftest_ctrl_status, .rail_voltage_supervisor_emul_en, .clk_fail_emul,
    .clock_loss_flag, .supply_supervision_en, .buck_prereg_rail_en, .io_rail_cfg_en, .rail_5v_fixed_en,
    .sensor_rail_en, .ilim_status, .clk_fail_latched, .diag_output_pin, .analog_mux_en, .analog_mux_ch
  );
  ssd_mcu_model mcu (
    .ref_clk, .analog_selftest_ctrl_start, .analog_selftest_ctrl_sel, .clk_recheck, .status_read, .go_active, .en_5v_set, .en_sensor_set,
    .diag_config_reg, .diag_source_select
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_st(input logic [4:0] s);
    int k;
    k = 0;
    while (dev_state !== s && k < 400) begin
      settle(1);
      k++;
    end
    if (dev_state !== s) begin
      chk(16'(dev_state), 16'(s));
      wrap_up();
    end
  endtask
  // Runs one self-test; with t set the monitored inputs toggle early in the run.
  task automatic run(input logic [5:0] k, input logic [2:0] s, input logic t);
    mcu.req(k, s);
    seen = 1'b0;
    sup = 1'b0;
    n = 0;
    #1;
    chk({14'h0, clk_fail_emul, rail_voltage_supervisor_emul_en}, {14'h0, k == K_CLK || s[CHK_CLK], k == K_RUN && s[CHK_RAIL_VOLTAGE_SUPERVISOR]});
    while (analog_selftest_ctrl_running === 1'b1 && n < 300) begin
      seen = seen | clock_loss_flag;
      sup = sup | supply_supervision_en;
      @(posedge ref_clk);
      if (t && n < 32 && n[1:0] == 2'h0) begin
        clock_loss_monitor <= ~clock_loss_monitor;
        rail_cmp_in <= ~rail_cmp_in;
      end
      n++;
      #1;
    end
  endtask
  function automatic logic ex_ana();
    return diag_config_reg[MUX_EN_BIT] && diag_config_reg[1:0] == MUX_TYPE_ANA && diag_source_select[3:0] <= 4'h7;
  endfunction
  function automatic logic ex_dout();
    logic [15:0] g;
    case (diag_source_select[6:4])
      GRP_0: g = {1'b0, rail_cmp_in, analog_supply_uv_flag, 1'b0};
      GRP_1: g = {digital_source_mux_grp1_in[15:1], 1'b0};
      GRP_2: g = {digital_source_mux_grp2_in[15:1], 1'b0};
      GRP_3: g = {digital_source_mux_grp3_in[15:1], 1'b0};
      GRP_7: g = {digital_source_mux_grp7_in[15:1], 1'b0};
      default: g = 16'h0000;
    endcase
    return diag_config_reg[MUX_EN_BIT] && diag_config_reg[1:0] == MUX_TYPE_DIG && g[diag_source_select[3:0]];
  endfunction

  initial begin
    errors = 0;
    total_checks = 0;
    {rst_b, ignition_wake_in, bus_wake_in, clock_loss_monitor, analog_supply_uv_flag} = 5'h00;
    {rail_cmp_in, ot_in, ilim_in} = 19'h00000;
    {digital_source_mux_grp1_in, digital_source_mux_grp2_in, digital_source_mux_grp3_in, digital_source_mux_grp7_in} = 64'h0;
    trim_crc_ok = 1'b1;
    void'($urandom(66));
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    ignition_wake_in <= 1'b1;
    wait_st(ST_DIAG);
    for (i = 0; i < 32; i++) begin
      @(posedge ref_clk);
      analog_supply_uv_flag <= 1'($urandom);
      rail_cmp_in <= 13'($urandom);
      {digital_source_mux_grp1_in, digital_source_mux_grp2_in} <= {16'($urandom), 16'($urandom)};
      {digital_source_mux_grp3_in, digital_source_mux_grp7_in} <= {16'($urandom), 16'($urandom)};
      mcu.cfg({(i < 24) | 1'($urandom), 5'($urandom), 2'(i)}, 7'($urandom));
      settle(6);
      chk({14'h0, analog_mux_en, diag_output_pin}, {14'h0, ex_ana(), ex_dout()});
      if (ex_ana()) chk(16'(analog_mux_ch), 16'(diag_source_select[2:0]));
    end
    run(K_RUN, 3'h7, 1'b1);
    chk(16'(n), 16'd64);
    chk({14'h0, seen, sup}, 16'h0002);
    settle(3);
    chk({7'h0, dev_state, analog_selftest_ctrl_status}, {7'h0, ST_DIAG, 4'h0});
    mcu.req(K_ACT, 3'h0);
    settle(2);
    chk(16'(dev_state), 16'(ST_ACTIVE));
    run(K_CLK, 3'h0, 1'b1);
    settle(3);
    chk({10'h0, seen, dev_state}, {10'h0, 1'b1, ST_ACTIVE});
    run(K_RUN, 3'h1, 1'b0);
    settle(3);
    chk({6'h0, dev_state, mcu_reset_out_n, analog_selftest_ctrl_status}, {6'h0, ST_SAFE, 1'b0, 4'h1});
    @(posedge ref_clk);
    ignition_wake_in <= 1'b0;
    bus_wake_in <= 1'b1;
    wait_st(ST_DIAG);
    chk(16'(analog_selftest_ctrl_status), 16'h0009);
    mcu.req(K_RD, 3'h0);
    settle(2);
    chk(16'(analog_selftest_ctrl_status), 16'h0000);
    mcu.req(K_SNS, 3'h0);
    settle(2);
    chk(16'(sensor_rail_en), 16'h0001);
    ot_in <= 3'h4;
    settle(5);
    mcu.req(K_SNS, 3'h0);
    ot_in <= 3'h0;
    settle(5);
    chk({11'h0, sensor_rail_en, dev_state}, {11'h0, 1'b0, ST_DIAG});
    mcu.req(K_SNS, 3'h0);
    ilim_in <= 3'h2;
    settle(5);
    chk({12'h0, sensor_rail_en, ilim_status}, 16'h000a);
    ilim_in <= 3'h0;
    ot_in <= 3'h2;
    wait_st(ST_RESET);
    chk({11'h0, buck_prereg_rail_en, io_rail_cfg_en, rail_5v_fixed_en, sensor_rail_en, mcu_reset_out_n}, 16'h001a);
    ot_in <= 3'h1;
    wait_st(ST_STANDBY);
    chk({11'h0, buck_prereg_rail_en, io_rail_cfg_en, rail_5v_fixed_en, sensor_rail_en, mcu_reset_out_n}, 16'h0000);
    ot_in <= 3'h0;
    wait_st(ST_DIAG);
    mcu.req(K_5V, 3'h0);
    clock_loss_monitor <= 1'b0;
    settle(2);
    clock_loss_monitor <= 1'b1;
    wait_st(ST_STANDBY);
    settle(20);
    chk({9'h0, dev_state, clk_fail_latched, mcu_reset_out_n}, {9'h0, ST_STANDBY, 1'b1, 1'b0});
    wrap_up();
  end
endmodule // safety_selftest_diag_mux_tb_top
`default_nettype wire
